// ### include/mcs_map.svh
// Purpose: Constants for the CAN message slot controller
// Assumes: 40 MHz sys_clk, frames arrive already error checked
// Notes:   Types live in mcs_pkg
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
`define MCS_NUM_SLOTS      16
`define MCS_TS_SLOTS       8
`define MCS_TS_BITTIMES    32
`define MCS_TS_NONE        8'hFF
`define MCS_MAX_LEN        4'h8
`define MCS_RST_MASK       11'h000
`define MCS_LOAD_TX        2'h0
`define MCS_LOAD_MASK      2'h1
`define MCS_LOAD_REMOTE    2'h2
`define MCS_LOAD_RESPONSE  2'h3
`define MCS_TRIP_OFF       2'h0
`define MCS_TRIP_BUSOFF    2'h1
`define MCS_TRIP_ALL       2'h2
`define MCS_CRC_POLY       15'h4599
`define MCS_BIT_CYCLES     40
`endif

// ### include/mcs_pkg.sv
// Purpose: Types shared by the slot controller files
// Assumes: Nothing
// Notes:   Constants are in mcs_map.svh
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_ST_EMPTY,
    MCS_ST_TXPEND,
    MCS_ST_RXNEW
  } mcs_status_t;

  typedef enum logic [2:0] {
    MCS_OP_LOAD,
    MCS_OP_READ,
    MCS_OP_STATUS,
    MCS_OP_TRIP,
    MCS_OP_TIMER
  } mcs_op_t;

  typedef struct packed {
    logic [10:0] id;
    logic        rtr;
    logic [3:0]  len;
    logic [63:0] data;
  } mcs_frame_t;

  typedef struct packed {
    mcs_op_t     op;
    logic [3:0]  slot;
    logic [1:0]  code;
    logic [1:0]  arg;
    mcs_frame_t  frame;
  } mcs_cmd_t;

  typedef struct packed {
    logic        ok;
    logic [1:0]  status;
    mcs_frame_t  frame;
    logic [7:0]  tstamp;
  } mcs_rsp_t;
endpackage

// ### src/mcs_txsel.sv
// Purpose: Picks the pending transmit slot with the lowest identifier
// Assumes: Ties go to the lower slot number
// Notes:   Pure combinational arbiter
`timescale 1ns/1ps
module mcs_txsel #(
  parameter int N = 16
) (
  input  wire logic [N-1:0]       pend,
  input  wire logic [N*11-1:0]    ids,
  output      logic               any,
  output      logic [$clog2(N)-1:0] sel
);
  logic [10:0] best;
  always_comb begin
    any  = 1'b0;
    sel  = '0;
    best = 11'h7FF;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && (!any || ids[i*11 +: 11] < best)) begin
        any  = 1'b1;
        sel  = i[$clog2(N)-1:0];
        best = ids[i*11 +: 11];
      end
    end
  end
endmodule

// ### src/mcs_ctrl.sv
// Purpose: CAN message slot controller, host side and frame side
// Assumes: Received frames are presented after error checking
// Notes:   Bit-level line coding lives in the attached MAC
`timescale 1ns/1ps
`include "mcs_map.svh"
module mcs_ctrl #(
  parameter int NSLOT      = `MCS_NUM_SLOTS,
  parameter int BIT_CYCLES = `MCS_BIT_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              cmd_valid,
  input  wire mcs_pkg::mcs_cmd_t cmd,
  output      logic              rsp_valid,
  output      mcs_pkg::mcs_rsp_t rsp,
  input  wire logic              rx_valid,
  input  wire mcs_pkg::mcs_frame_t rx_frame,
  output      logic              tx_valid,
  output      mcs_pkg::mcs_frame_t tx_frame,
  output      logic [14:0]       tx_crc,
  input  wire logic              tx_done,
  input  wire logic              bus_off,
  input  wire logic              net_err,
  output      logic              bus_off_trip,
  output      logic              network_error_trip,
  output      logic [7:0]        timer_now
);
  localparam int SW = $clog2(NSLOT);
  localparam int PRE_CYCLES = BIT_CYCLES * `MCS_TS_BITTIMES;

  mcs_pkg::mcs_status_t stat [NSLOT];
  mcs_pkg::mcs_frame_t  frm  [NSLOT];
  logic [10:0]          mask [NSLOT];
  logic [7:0]           ts   [NSLOT];
  logic [NSLOT-1:0]     rx_en;
  mcs_pkg::mcs_frame_t  resp_frame;
  logic [1:0]           trip_mode;
  logic [$clog2(PRE_CYCLES)-1:0] pre_cnt;
  logic                 tick;
  logic [SW-1:0]        tx_slot;

  //////////////////////////////////////////////////////////////////////////
  // Receive match, one comparator per slot
  logic [NSLOT-1:0]  hit;
  logic [NSLOT*11-1:0] ids;
  logic [NSLOT-1:0]  pend;
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      assign hit[g] = rx_en[g] && mask[g] == rx_frame.id
                      && stat[g] == mcs_pkg::MCS_ST_EMPTY;
      assign ids[g*11 +: 11] = frm[g].id;
      assign pend[g] = stat[g] == mcs_pkg::MCS_ST_TXPEND;
    end
  endgenerate

  // Duplicate masks resolve to the highest free slot
  logic          rx_take;
  logic [SW-1:0] rx_slot;
  always_comb begin
    rx_take = 1'b0;
    rx_slot = '0;
    for (int i = 0; i < NSLOT; i++) begin
      if (hit[i]) begin
        rx_take = rx_valid;
        rx_slot = i[SW-1:0];
      end
    end
  end

  logic          tx_any;
  logic [SW-1:0] tx_pick;
  mcs_txsel #(.N(NSLOT)) u_txsel (
    .pend (pend),
    .ids  (ids),
    .any  (tx_any),
    .sel  (tx_pick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Host command decode
  logic is_load;
  logic is_read;
  logic load_ok;
  logic read_ok;
  assign is_load = cmd_valid && cmd.op == mcs_pkg::MCS_OP_LOAD;
  assign is_read = cmd_valid && cmd.op == mcs_pkg::MCS_OP_READ;
  assign load_ok = is_load && cmd.frame.len <= `MCS_MAX_LEN;
  assign read_ok = is_read && stat[cmd.slot] == mcs_pkg::MCS_ST_RXNEW;

  // Unused data bytes are forced to zero
  function automatic mcs_pkg::mcs_frame_t clean(mcs_pkg::mcs_frame_t f);
    mcs_pkg::mcs_frame_t r;
    r = f;
    for (int b = 0; b < 8; b++) begin
      if (b >= f.len) begin
        r.data[b*8 +: 8] = 8'h00;
      end
    end
    return r;
  endfunction

  // CRC over start bit, arbitration, control and data fields
  function automatic logic [14:0] crc15(mcs_pkg::mcs_frame_t f);
    logic [82:0] bits;
    logic [14:0] c;
    logic        nb;
    int          n;
    bits = '0;
    c    = 15'h0000;
    n    = 19 + 8 * int'(f.len);
    bits[82:64] = {1'b0, f.id, f.rtr, 2'b00, f.len};
    for (int b = 0; b < 8; b++) begin
      bits[63 - b*8 -: 8] = f.data[b*8 +: 8];
    end
    for (int i = 0; i < 83; i++) begin
      if (i < n) begin
        nb = bits[82 - i] ^ c[14];
        c  = {c[13:0], 1'b0};
        if (nb) begin
          c = c ^ `MCS_CRC_POLY;
        end
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Time-stamp timer, one count per 32 bit times
  logic timer_clr;
  assign timer_clr = cmd_valid && cmd.op == mcs_pkg::MCS_OP_TIMER
                     && cmd.arg == 2'h1;

  // Prescaler restarts too, else the first count after a clear comes early
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else if (timer_clr) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= pre_cnt == ($clog2(PRE_CYCLES))'(PRE_CYCLES - 1);
      pre_cnt <= (pre_cnt == ($clog2(PRE_CYCLES))'(PRE_CYCLES - 1))
                 ? '0 : pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_now <= 8'h00;
    end else if (cmd_valid && cmd.op == mcs_pkg::MCS_OP_TIMER
                 && cmd.arg == 2'h1) begin
      timer_now <= 8'h00;
    end else if (tick) begin
      timer_now <= timer_now + 8'h01; // Wraps after 255
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slot storage; a host load wins over a finished transmission
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NSLOT; i++) begin
        stat[i] <= mcs_pkg::MCS_ST_EMPTY;
        frm[i]  <= '0;
        ts[i]   <= 8'h00;
        mask[i] <= `MCS_RST_MASK;
      end
      rx_en      <= '1;
      resp_frame <= '0;
    end else begin
      if (tx_done && tx_valid) begin
        stat[tx_slot] <= mcs_pkg::MCS_ST_EMPTY;
      end
      if (rx_take) begin
        frm[rx_slot]  <= clean(rx_frame);
        stat[rx_slot] <= mcs_pkg::MCS_ST_RXNEW;
        if (rx_slot < SW'(`MCS_TS_SLOTS)) begin
          ts[rx_slot] <= timer_now;
        end
      end
      if (read_ok) begin
        stat[cmd.slot] <= mcs_pkg::MCS_ST_EMPTY;
      end
      if (load_ok) begin
        case (cmd.code)
          `MCS_LOAD_TX, `MCS_LOAD_REMOTE: begin
            frm[cmd.slot]     <= clean(cmd.frame);
            frm[cmd.slot].rtr <= cmd.code == `MCS_LOAD_REMOTE;
            stat[cmd.slot]    <= mcs_pkg::MCS_ST_TXPEND;
            rx_en[cmd.slot]   <= 1'b0;
          end
          `MCS_LOAD_MASK: begin
            mask[cmd.slot]  <= cmd.frame.id;
            rx_en[cmd.slot] <= 1'b1;
          end
          `MCS_LOAD_RESPONSE: begin
            resp_frame <= clean(cmd.frame);
          end
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit offer; the MAC arbitrates and reports tx_done
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_slot  <= '0;
      tx_frame <= '0;
      tx_crc   <= 15'h0000;
    end else begin
      tx_valid <= tx_any && !(tx_done && tx_valid && tx_pick == tx_slot);
      tx_slot  <= tx_pick;
      tx_frame <= frm[tx_pick];
      tx_crc   <= crc15(frm[tx_pick]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trip setting and trip outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_mode <= `MCS_TRIP_OFF;
    end else if (cmd_valid && cmd.op == mcs_pkg::MCS_OP_TRIP
                 && cmd.arg <= `MCS_TRIP_ALL) begin
      trip_mode <= cmd.arg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_off_trip       <= 1'b0;
      network_error_trip <= 1'b0;
    end else begin
      bus_off_trip       <= bus_off && trip_mode != `MCS_TRIP_OFF;
      network_error_trip <= net_err && trip_mode == `MCS_TRIP_ALL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Host answers, one cycle after the command
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid  <= cmd_valid;
      rsp        <= '0;
      rsp.status <= stat[cmd.slot];
      case (cmd.op)
        mcs_pkg::MCS_OP_LOAD:   rsp.ok <= load_ok;
        mcs_pkg::MCS_OP_STATUS: rsp.ok <= 1'b1;
        mcs_pkg::MCS_OP_TRIP:   rsp.ok <= cmd.arg <= `MCS_TRIP_ALL;
        mcs_pkg::MCS_OP_TIMER:  rsp.ok <= 1'b1;
        mcs_pkg::MCS_OP_READ: begin
          rsp.ok <= read_ok;
          if (read_ok) begin
            rsp.frame  <= frm[cmd.slot];
            rsp.tstamp <= (cmd.slot < SW'(`MCS_TS_SLOTS))
                          ? ts[cmd.slot] : `MCS_TS_NONE;
          end
        end
        default: rsp.ok <= 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_rx_store;
    rx_take |=> stat[$past(rx_slot)] == mcs_pkg::MCS_ST_RXNEW;
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("Matched frame not stored");

  // Per slot checks, independent of the match and pick logic
  generate
    for (g = 0; g < NSLOT; g++) begin : g_chk
      property p_no_match;
        rx_valid && (mask[g] != rx_frame.id || !rx_en[g])
          && stat[g] != mcs_pkg::MCS_ST_RXNEW
          |=> stat[g] != mcs_pkg::MCS_ST_RXNEW;
      endproperty
      a_no_match: assert property (p_no_match)
        else $error("Unmatched frame taken");

      property p_full_reject;
        rx_valid && stat[g] == mcs_pkg::MCS_ST_RXNEW
          && !(cmd_valid && cmd.slot == g) |=> $stable(frm[g]);
      endproperty
      a_full_reject: assert property (p_full_reject)
        else $error("Frame stored over unread frame");

      property p_lowest;
        tx_valid && $past(pend[g]) && $stable(frm[g].id)
          |-> tx_frame.id <= frm[g].id;
      endproperty
      a_lowest: assert property (p_lowest)
        else $error("Transmit not lowest identifier");
    end
  endgenerate

  property p_tx_load;
    load_ok && cmd.code == `MCS_LOAD_TX |=> !rx_en[$past(cmd.slot)]
      && stat[$past(cmd.slot)] == mcs_pkg::MCS_ST_TXPEND;
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("Transmit load left mask active");

  property p_timer_clr;
    cmd_valid && cmd.op == mcs_pkg::MCS_OP_TIMER && cmd.arg == 2'h1
      |=> timer_now == 8'h00;
  endproperty
  a_timer_clr: assert property (p_timer_clr)
    else $error("Timer not cleared");

  property p_trip_net;
    network_error_trip |-> $past(net_err) && trip_mode == `MCS_TRIP_ALL
      || $past(trip_mode) == `MCS_TRIP_ALL;
  endproperty
  a_trip_net: assert property (p_trip_net)
    else $error("Network trip while disabled");

  property p_read_stamp;
    is_read && cmd.slot >= SW'(`MCS_TS_SLOTS) && read_ok
      |=> rsp_valid && rsp.ok && rsp.tstamp == `MCS_TS_NONE;
  endproperty
  a_read_stamp: assert property (p_read_stamp)
    else $error("Upper slot stamp not -1");

  property p_read_empty;
    read_ok |=> ##1 stat[$past(cmd.slot, 2)] != mcs_pkg::MCS_ST_RXNEW
      || $past(rx_take);
  endproperty
  a_read_empty: assert property (p_read_empty)
    else $error("Read did not empty slot");
endmodule

// ### verif/mcs_mac_model.sv
// Purpose: Bus side model: other nodes and the line MAC
// Assumes: Frames it hands over are already error checked
// Notes:   wait_cyc sets how long a transmission takes
`timescale 1ns/1ps
module mcs_mac_model (
  input  wire logic                sys_clk,
  input  wire logic                tx_valid,
  input  wire mcs_pkg::mcs_frame_t tx_frame,
  input  wire logic [14:0]         tx_crc,
  output      logic                tx_done,
  output      logic                rx_valid,
  output      mcs_pkg::mcs_frame_t rx_frame
);
  int                  wait_cyc = 3;
  mcs_pkg::mcs_frame_t sent_q[$];
  logic [14:0]         crc_q[$];

  initial begin
    tx_done = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ids stay 11 bit, at most 8 bytes, unused bytes zero
  task automatic send(input mcs_pkg::mcs_frame_t f);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b1;
    rx_frame = f;
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    // Released lines show garbage so stale data is never trusted
    rx_frame = ~f;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Frame recorded as offered at the moment it leaves the wire
  always begin
    @(posedge sys_clk);
    #1;
    if (tx_valid === 1'b1) begin
      repeat (wait_cyc) @(posedge sys_clk);
      #1;
      tx_done = 1'b1;
      sent_q.push_back(tx_frame);
      crc_q.push_back(tx_crc);
      @(posedge sys_clk);
      #1;
      tx_done = 1'b0;
      @(posedge sys_clk);
    end
  end
endmodule

// ### verif/testbench.sv
// Purpose: Self-checking bench for the slot controller
// Assumes: BIT_CYCLES=1, so one stamp count is 32 clocks
// Notes:   Waits are bounded; a watchdog ends a hang
`timescale 1ns/1ps
`include "mcs_map.svh"
module testbench;
  logic                sys_clk;
  logic                rst_b;
  logic                cmd_valid;
  mcs_pkg::mcs_cmd_t   cmd;
  logic                rsp_valid;
  mcs_pkg::mcs_rsp_t   rsp;
  logic                rx_valid;
  mcs_pkg::mcs_frame_t rx_frame;
  logic                tx_valid;
  mcs_pkg::mcs_frame_t tx_frame;
  logic                tx_done;
  logic                bus_off;
  logic                net_err;
  logic                bus_off_trip;
  logic                network_error_trip;
  logic [14:0]         tx_crc;
  logic [7:0]          timer_now;
  mcs_pkg::mcs_rsp_t   r;
  int                  n_fail = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  t0;

  mcs_ctrl #(.BIT_CYCLES(1)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_crc(tx_crc), .tx_done(tx_done), .bus_off(bus_off), .net_err(net_err),
    .bus_off_trip(bus_off_trip), .network_error_trip(network_error_trip),
    .timer_now(timer_now)
  );

  mcs_mac_model u_mac (
    .sys_clk(sys_clk), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_crc(tx_crc),
    .tx_done(tx_done), .rx_valid(rx_valid), .rx_frame(rx_frame)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Wide enough for ok, a whole frame and a stamp
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic mcs_pkg::mcs_frame_t fr(input logic [10:0] id,
      input logic [3:0] n, input logic [63:0] d);
    fr = '{id, 1'b0, n, d};
  endfunction

  // Reference CRC-15, serial over start bit through the last data byte
  function automatic logic [14:0] crc_ref(input mcs_pkg::mcs_frame_t f);
    logic [14:0] c;
    logic [82:0] s;
    c = 15'h0000;
    s = {1'b0, f.id, f.rtr, 2'b00, f.len, 64'h0};
    for (int b = 0; b < 8; b++) s[63 - 8 * b -: 8] = f.data[8 * b +: 8];
    for (int i = 0; i < 19 + 8 * f.len; i++) begin
      c = {c[13:0], 1'b0}
          ^ ((s[82 - i] ^ c[14]) ? `MCS_CRC_POLY : 15'h0000);
    end
    return c;
  endfunction

  // One command, answer captured in r
  task automatic run(input mcs_pkg::mcs_op_t op, input logic [3:0] s,
      input logic [1:0] c, input logic [1:0] a, input mcs_pkg::mcs_frame_t f);
    int k;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op, s, c, a, f};
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (k = 0; k < 4 && rsp_valid !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (rsp_valid !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no answer", $time);
      close_out();
    end
    r = rsp;
  endtask

  task automatic stat(input logic [3:0] s, input logic [1:0] e);
    run(mcs_pkg::MCS_OP_STATUS, s, 2'h0, 2'h0, '0);
    chk({r.ok, r.status}, {1'b1, e});
  endtask

  task automatic rd(input logic [3:0] s, input mcs_pkg::mcs_frame_t f,
      input logic [7:0] t);
    run(mcs_pkg::MCS_OP_READ, s, 2'h0, 2'h0, '0);
    chk({r.ok, r.frame, r.tstamp}, {1'b1, f, t});
  endtask

  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 300 && u_mac.sent_q.size() < n; k++) @(posedge sys_clk);
    if (u_mac.sent_q.size() < n) begin
      n_fail++;
      $display("[ERR] %0t transmit missing", $time);
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] %0t watchdog", $time);
    close_out();
  end

  initial begin
    int i;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    bus_off = 1'b0;
    net_err = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    for (i = 0; i < 16; i++) stat(4'(i), 2'h0);
    u_mac.send(fr(11'h155, 4'h1, 64'hAA));
    for (i = 0; i < 16; i++) stat(4'(i), 2'h0);
    u_mac.send(fr(11'h000, 4'h2, 64'h1234));
    u_mac.send(fr(11'h000, 4'h1, 64'h56));
    stat(4'hF, 2'h2);
    stat(4'hE, 2'h2);
    rd(4'hF, fr(11'h000, 4'h2, 64'h1234), 8'hFF);
    stat(4'hF, 2'h0);
    run(mcs_pkg::MCS_OP_READ, 4'hF, 2'h0, 2'h0, '0);
    chk(r.ok, 1'b0);
    // Receive through a configured mask, second frame must bounce
    run(mcs_pkg::MCS_OP_LOAD, 4'h8, 2'h1, 2'h0, fr(11'h0D3, 4'h0, 64'h0));
    chk(r.ok, 1'b1);
    u_mac.send(fr(11'h0D3, 4'h2, 64'h5A3C));
    u_mac.send(fr(11'h0D3, 4'h1, 64'h77));
    stat(4'h8, 2'h2);
    rd(4'h8, fr(11'h0D3, 4'h2, 64'h5A3C), 8'hFF);
    // Time-stamps, clear, no-op and wrap
    run(mcs_pkg::MCS_OP_LOAD, 4'h3, 2'h1, 2'h0, fr(11'h0D4, 4'h0, 64'h0));
    run(mcs_pkg::MCS_OP_LOAD, 4'h4, 2'h1, 2'h0, fr(11'h0D5, 4'h0, 64'h0));
    run(mcs_pkg::MCS_OP_TIMER, 4'h0, 2'h0, 2'h1, '0);
    t0 = cyc;
    chk(r.ok, 1'b1);
    chk(timer_now, 8'h00);
    u_mac.send(fr(11'h0D4, 4'h1, 64'h11));
    while (cyc < t0 + 70) @(posedge sys_clk);
    run(mcs_pkg::MCS_OP_TIMER, 4'h0, 2'h0, 2'h0, '0);
    chk(r.ok, 1'b1);
    chk(timer_now, 8'h02);
    while (cyc < t0 + 80) @(posedge sys_clk);
    u_mac.send(fr(11'h0D5, 4'h1, 64'h22));
    rd(4'h3, fr(11'h0D4, 4'h1, 64'h11), 8'h00);
    rd(4'h4, fr(11'h0D5, 4'h1, 64'h22), 8'h02);
    while (cyc < t0 + 8208) @(posedge sys_clk);
    u_mac.send(fr(11'h0D4, 4'h1, 64'h33));
    rd(4'h3, fr(11'h0D4, 4'h1, 64'h33), 8'h00);
    // Three queued sends while the bus is slow
    u_mac.wait_cyc = 20;
    run(mcs_pkg::MCS_OP_LOAD, 4'h2, 2'h0, 2'h0, fr(11'h300, 4'h1, 64'h9));
    run(mcs_pkg::MCS_OP_LOAD, 4'h8, 2'h0, 2'h0, fr(11'h200, 4'h2, 64'h1));
    run(mcs_pkg::MCS_OP_LOAD, 4'h5, 2'h0, 2'h0, fr(11'h100, 4'h8, 64'h7));
    stat(4'h2, 2'h1);
    wait_tx(3);
    chk(u_mac.sent_q[0], fr(11'h100, 4'h8, 64'h7));
    chk(u_mac.sent_q[1], fr(11'h200, 4'h2, 64'h1));
    chk(u_mac.sent_q[2], fr(11'h300, 4'h1, 64'h9));
    chk(u_mac.crc_q[0], crc_ref(fr(11'h100, 4'h8, 64'h7)));
    chk(u_mac.crc_q[2], crc_ref(fr(11'h300, 4'h1, 64'h9)));
    stat(4'h2, 2'h0);
    u_mac.send(fr(11'h0D3, 4'h1, 64'h44));
    stat(4'h8, 2'h0);
    // Remaining load codes and an oversized length
    u_mac.wait_cyc = 1;
    run(mcs_pkg::MCS_OP_LOAD, 4'h1, 2'h3, 2'h0, fr(11'h4D3, 4'h2, 64'h5));
    chk(r.ok, 1'b1);
    stat(4'h1, 2'h0);
    run(mcs_pkg::MCS_OP_LOAD, 4'h7, 2'h2, 2'h0, fr(11'h4D3, 4'h0, 64'h0));
    wait_tx(4);
    chk(u_mac.sent_q[3], {11'h4D3, 1'b1, 4'h0, 64'h0});
    chk(u_mac.crc_q[3], crc_ref({11'h4D3, 1'b1, 4'h0, 64'h0}));
    run(mcs_pkg::MCS_OP_LOAD, 4'h6, 2'h0, 2'h0, fr(11'h010, 4'h9, 64'h0));
    chk(r.ok, 1'b0);
    stat(4'h6, 2'h0);
    // Trip modes, then an illegal argument that must not change them
    bus_off = 1'b1;
    net_err = 1'b1;
    for (i = 0; i < 4; i++) begin
      run(mcs_pkg::MCS_OP_TRIP, 4'h0, 2'h0, 2'(i), '0);
      chk(r.ok, 1'(i != 3));
      repeat (3) @(posedge sys_clk);
      #1;
      chk({bus_off_trip, network_error_trip}, {i != 0, i >= 2});
    end
    close_out();
  end
endmodule
